/* src/proc_mem_map.svh */
// timing constants and field widths for the processor memory request port
`ifndef PROC_MEM_MAP_SVH
`define PROC_MEM_MAP_SVH
`define PMR_ADDR_W 12
`define PMR_DATA_W 17
`define PMR_REPLY_ON 8'h0A
`define PMR_RELEASE 8'h1E
`define PMR_REPLY_OFF 8'h46
`define PMR_BUSY_DELAY 8'h08
`define PMR_CLK_NS 40
`endif

/* src/proc_mem_pkg.sv */
// types for the processor memory request port
package proc_mem_pkg;
   typedef enum logic [2:0] {
      REQ_IDLE = 3'b000,
      REQ_WAIT = 3'b001,
      REQ_STEP1 = 3'b010,
      REQ_STEP2 = 3'b011,
      REQ_CYCLE = 3'b100,
      REQ_REPLY = 3'b101
   } req_state_t;
endpackage

/* src/proc_mem_if.sv */
// processor to controller memory request link
`timescale 1ns/100ps
`default_nettype none
`include "proc_mem_map.svh"
interface proc_mem_if;
   logic procMemRequest;
   logic procStoreSelect;
   logic [`PMR_ADDR_W-1:0] procAddressLines;
   logic [`PMR_DATA_W-1:0] procStoreDataLines;
   logic procReply;
   modport device (input procMemRequest, input procStoreSelect, input procAddressLines,
      input procStoreDataLines, output procReply);
   modport host (output procMemRequest, output procStoreSelect, output procAddressLines,
      output procStoreDataLines, input procReply);
endinterface
`default_nettype wire

/* src/pmr_counter.sv */
// saturating step counter used by the delay line and reply chain
`timescale 1ns/100ps
`default_nettype none
module pmr_counter #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic run,
   output logic [W-1:0] count
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= '0;
      end else if (start) begin
         count <= {{(W-1){1'b0}}, 1'b1};
      end else if (run && count != {W{1'b1}}) begin
         count <= count + {{(W-1){1'b0}}, 1'b1};
      end
   end
endmodule
`default_nettype wire

/* src/proc_mem_device.sv */
// controller end: captures processor requests and runs memory and reply chains
`timescale 1ns/100ps
`default_nettype none
`include "proc_mem_map.svh"
module proc_mem_device #(
   parameter logic [7:0] REPLY_ON = `PMR_REPLY_ON,
   parameter logic [7:0] RELEASE_AT = `PMR_RELEASE,
   parameter logic [7:0] REPLY_OFF = `PMR_REPLY_OFF,
   parameter logic [7:0] BUSY_DELAY = `PMR_BUSY_DELAY
) (
   input wire logic clk,
   input wire logic rst_n,
   proc_mem_if.device link,
   input wire logic scannerAtProc,
   input wire logic memoryBusyIn,
   input wire logic memoryDataReady,
   input wire logic [`PMR_DATA_W-1:0] memReadData,
   output logic grantRoute,
   output logic storeCycle,
   output logic memoryCycleRequest,
   output logic [`PMR_ADDR_W-1:0] memAddress,
   output logic [`PMR_DATA_W-1:0] memWriteData,
   output logic readPathEnable,
   output logic [`PMR_DATA_W-1:0] procReadData,
   output logic busy,
   output logic scannerHold,
   output logic clearOtherRequests
);
   proc_mem_pkg::req_state_t state_q;
   logic procReq1_q, procReq2_q, procReq3_q, inProgress_q, intBusy_q;
   logic grant_q, store_q, memory_cycle_request_q, reply_q, busy_q, chainRun_q, delayRun_q;
   logic [`PMR_ADDR_W-1:0] addr_q;
   logic [`PMR_DATA_W-1:0] wdata_q, rdata_q;
   logic [1:0] busySync_q, readySync_q;
   logic readyPrev_q;
   logic [7:0] chainCount, delayCount;
   logic readyRise, stepOne, stepTwo, delayDone, atRelease, atOff;

   // pins from memory are asynchronous to our clock
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busySync_q <= 2'h0;
         readySync_q <= 2'h0;
         readyPrev_q <= 1'b0;
      end else begin
         busySync_q <= {busySync_q[0], memoryBusyIn};
         readySync_q <= {readySync_q[0], memoryDataReady};
         readyPrev_q <= readySync_q[1];
      end
   end

   assign readyRise = readySync_q[1] && !readyPrev_q;
   assign stepOne = (state_q == proc_mem_pkg::REQ_STEP1);
   assign stepTwo = (state_q == proc_mem_pkg::REQ_STEP2);
   assign atRelease = chainRun_q && chainCount == RELEASE_AT;
   assign atOff = chainRun_q && chainCount == REPLY_OFF;
   assign delayDone = delayCount >= BUSY_DELAY;

   pmr_counter #(.W(8)) replyChain (
      .clk(clk), .rst_n(rst_n), .start(readyRise && inProgress_q),
      .run(chainRun_q), .count(chainCount));

   pmr_counter #(.W(8)) busyDelay (
      .clk(clk), .rst_n(rst_n), .start(stepTwo),
      .run(delayRun_q), .count(delayCount));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= proc_mem_pkg::REQ_IDLE;
      end else begin
         case (state_q)
            proc_mem_pkg::REQ_IDLE: begin
               if (procReq1_q && procReq2_q && scannerAtProc) begin
                  state_q <= proc_mem_pkg::REQ_WAIT;
               end
            end
            proc_mem_pkg::REQ_WAIT: begin
               if (!busy_q && !busySync_q[1]) begin
                  state_q <= proc_mem_pkg::REQ_STEP1;
               end
            end
            proc_mem_pkg::REQ_STEP1: state_q <= proc_mem_pkg::REQ_STEP2;
            proc_mem_pkg::REQ_STEP2: state_q <= proc_mem_pkg::REQ_CYCLE;
            proc_mem_pkg::REQ_CYCLE: begin
               if (readyRise) begin
                  state_q <= proc_mem_pkg::REQ_REPLY;
               end
            end
            proc_mem_pkg::REQ_REPLY: begin
               if (atOff) begin
                  state_q <= proc_mem_pkg::REQ_IDLE;
               end
            end
            default: state_q <= proc_mem_pkg::REQ_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         procReq1_q <= 1'b0;
      end else if (link.procMemRequest && state_q == proc_mem_pkg::REQ_IDLE) begin
         procReq1_q <= 1'b1;
      end else if (stepTwo) begin
         procReq1_q <= 1'b0;
      end
   end

   // scanner sets second flop; released at time 30
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         procReq2_q <= 1'b0;
      end else if (atRelease) begin
         procReq2_q <= 1'b0;
      end else if (procReq1_q && scannerAtProc) begin
         procReq2_q <= 1'b1;
      end
   end
   assign scannerHold = procReq2_q;

   // grant and third flop; store; drop at time 70
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         procReq3_q <= 1'b1;
         grant_q <= 1'b0;
         store_q <= 1'b0;
         addr_q <= '0;
         wdata_q <= '0;
      end else if (atOff) begin
         procReq3_q <= 1'b1;
         grant_q <= 1'b0;
         store_q <= 1'b0;
      end else if (state_q == proc_mem_pkg::REQ_IDLE && procReq1_q && procReq2_q
                   && scannerAtProc) begin
         procReq3_q <= 1'b0;
         grant_q <= 1'b1;
         store_q <= link.procStoreSelect;
         addr_q <= link.procAddressLines;
         wdata_q <= link.procStoreDataLines;
      end
   end

   // request in progress and internal busy
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         inProgress_q <= 1'b0;
         intBusy_q <= 1'b1;
      end else if (stepTwo) begin
         inProgress_q <= 1'b1;
         intBusy_q <= 1'b0;
      end else if (atOff) begin
         inProgress_q <= 1'b0;
         intBusy_q <= 1'b1;
      end
   end

   // memory cycle request for one cycle after step two
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         memory_cycle_request_q <= 1'b0;
      end else begin
         memory_cycle_request_q <= stepTwo;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
         delayRun_q <= 1'b0;
      end else if (stepTwo) begin
         busy_q <= 1'b1;
         delayRun_q <= 1'b1;
      end else if (busy_q && !busySync_q[1] && delayDone && !memory_cycle_request_q) begin
         busy_q <= 1'b0;
         delayRun_q <= 1'b0;
      end
   end

   // reply chain and reply pulse; removal
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chainRun_q <= 1'b0;
         reply_q <= 1'b0;
         rdata_q <= '0;
      end else begin
         if (readyRise && inProgress_q) begin
            chainRun_q <= 1'b1;
            rdata_q <= memReadData;
         end else if (atOff) begin
            chainRun_q <= 1'b0;
         end
         if (chainRun_q && chainCount == REPLY_ON) begin
            reply_q <= 1'b1;
         end else if (atOff) begin
            reply_q <= 1'b0;
         end
      end
   end

   assign clearOtherRequests = stepOne;
   assign grantRoute = grant_q;
   assign storeCycle = store_q;
   assign readPathEnable = grant_q && !store_q;
   assign memoryCycleRequest = memory_cycle_request_q;
   assign memAddress = addr_q;
   assign memWriteData = wdata_q;
   assign procReadData = rdata_q;
   assign busy = busy_q;
   assign link.procReply = reply_q;
endmodule
`default_nettype wire

/* src/proc_mem_host.sv */
// processor end: raises requests and waits for the reply
`timescale 1ns/100ps
`default_nettype none
`include "proc_mem_map.svh"
module proc_mem_host (
   input wire logic clk,
   input wire logic rst_n,
   proc_mem_if.host link,
   input wire logic reqValid,
   input wire logic reqStore,
   input wire logic [`PMR_ADDR_W-1:0] reqAddress,
   input wire logic [`PMR_DATA_W-1:0] reqData,
   output logic reqReady,
   output logic done
);
   logic active_q, store_q, replyPrev_q, done_q;
   logic [`PMR_ADDR_W-1:0] addr_q;
   logic [`PMR_DATA_W-1:0] data_q;
   logic replyFall;

   // reply comes from a flop on our own clock, so it needs no sync stages
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         replyPrev_q <= 1'b0;
      end else begin
         replyPrev_q <= link.procReply;
      end
   end
   assign replyFall = replyPrev_q && !link.procReply;

   // request held until reply rises; address and data held until reply ends
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         active_q <= 1'b0;
         store_q <= 1'b0;
         addr_q <= '0;
         data_q <= '0;
         done_q <= 1'b0;
      end else begin
         done_q <= active_q && replyFall;
         if (!active_q && reqValid) begin
            active_q <= 1'b1;
            store_q <= reqStore;
            addr_q <= reqAddress;
            data_q <= reqData;
         end else if (active_q && replyFall) begin
            active_q <= 1'b0;
            store_q <= 1'b0;
         end
      end
   end

   assign reqReady = !active_q;
   assign done = done_q;
   // request kept low until active drops
   // the controller is idle again when the reply falls and would take a new request
   assign link.procMemRequest = active_q && !link.procReply && !replyPrev_q;
   assign link.procStoreSelect = store_q;
   assign link.procAddressLines = addr_q;
   assign link.procStoreDataLines = data_q;
endmodule
`default_nettype wire

/* bench/proc_mem_checker.sv */
// assertions on the processor memory link and the controller end's outputs
`timescale 1ns/100ps
`default_nettype none
`include "proc_mem_map.svh"
module proc_mem_checker #(
   parameter int REPLY_ON = 2,
   parameter int REPLY_OFF = 6
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic procMemRequest,
   input wire logic procStoreSelect,
   input wire logic [`PMR_ADDR_W-1:0] procAddressLines,
   input wire logic procReply,
   input wire logic scannerAtProc,
   input wire logic memoryBusyIn,
   input wire logic memoryDataReady,
   input wire logic grantRoute,
   input wire logic storeCycle,
   input wire logic memoryCycleRequest,
   input wire logic readPathEnable,
   input wire logic busy,
   input wire logic scannerHold,
   input wire logic clearOtherRequests
);
   // sync stages and chain start make the reply late by a few cycles
   localparam int ReplyLo = REPLY_ON + 1;
   localparam int ReplyHi = REPLY_ON + 6;
   logic [7:0] replyLen_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         replyLen_q <= 8'h00;
      end else begin
         replyLen_q <= procReply ? replyLen_q + 8'h01 : 8'h00;
      end
   end
   addr_held_a: assert property (
      procMemRequest && $past(procMemRequest) |-> $stable(procAddressLines))
      else $error("address moved during request");
   grant_after_scan_a: assert property ($rose(grantRoute) |-> $past(scannerAtProc))
      else $error("grant without scanner on slot");
   read_block_a: assert property (readPathEnable == (grantRoute && !storeCycle))
      else $error("read path wrong");
   store_follow_a: assert property (
      $rose(grantRoute) |-> storeCycle == $past(procStoreSelect))
      else $error("store cycle does not follow store select");
   step_idle_a: assert property (clearOtherRequests |-> !busy && grantRoute)
      else $error("timing chain started while busy");
   busy_set_a: assert property (clearOtherRequests |-> ##[1:2] busy)
      else $error("busy not raised by step two");
   cycle_req_a: assert property (
      clearOtherRequests |-> ##[1:3] memoryCycleRequest ##1 !memoryCycleRequest)
      else $error("memory cycle request missing");
   busy_kept_a: assert property (busy && memoryBusyIn |=> busy)
      else $error("busy dropped during memory busy");
   reply_time_a: assert property (
      $rose(memoryDataReady) |-> ##[ReplyLo:ReplyHi] procReply)
      else $error("reply late");
   slot_release_a: assert property ($fell(scannerHold) |-> procReply)
      else $error("slot released outside reply");
   reply_len_a: assert property (
      $fell(procReply) |-> replyLen_q == REPLY_OFF - REPLY_ON && !grantRoute && !storeCycle)
      else $error("reply length or grant drop wrong");
   busy_release_a: assert property (
      $fell(busy) |-> !$past(memoryBusyIn) && !$past(memoryBusyIn, 2))
      else $error("busy released too early");
endmodule
`default_nettype wire

/* bench/processor_memory_request_port_tb_top.sv */
// self-checking bench joining the processor end and the controller end
`timescale 1ns/100ps
`default_nettype none
`include "proc_mem_map.svh"
module processor_memory_request_port_tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic reqValid = 1'b0, reqStore = 1'b0, scannerAtProc = 1'b0;
   logic memoryBusyIn = 1'b0, memoryDataReady = 1'b0;
   logic [`PMR_ADDR_W-1:0] reqAddress = '0, memAddress, sawAddr;
   logic [`PMR_DATA_W-1:0] reqData = '0, memReadData = '0, memWord = '0;
   logic [`PMR_DATA_W-1:0] memWriteData, procReadData, sawWrite;
   logic reqReady, done, grantRoute, storeCycle, memoryCycleRequest, readPathEnable;
   logic busy, scannerHold, clearOtherRequests, sawStore, sawRead, sawClear;
   int mismatches = 0, testsRun = 0, memCount = 0, busyHold = 8, lastGap = 0;
   proc_mem_if link ();
   always #20 clk = ~clk;
   proc_mem_host i_proc_mem_host (.clk(clk), .rst_n(rst_n), .link(link.host),
      .reqValid(reqValid), .reqStore(reqStore), .reqAddress(reqAddress), .reqData(reqData),
      .reqReady(reqReady), .done(done));
   // busy delay keeps its default: it must outlast the memory's busy latency
   proc_mem_device #(.REPLY_ON(8'h02), .RELEASE_AT(8'h04), .REPLY_OFF(8'h06))
      i_proc_mem_device (.clk(clk), .rst_n(rst_n), .link(link.device),
      .scannerAtProc(scannerAtProc), .memoryBusyIn(memoryBusyIn),
      .memoryDataReady(memoryDataReady), .memReadData(memReadData), .grantRoute(grantRoute),
      .storeCycle(storeCycle), .memoryCycleRequest(memoryCycleRequest),
      .memAddress(memAddress), .memWriteData(memWriteData), .readPathEnable(readPathEnable),
      .procReadData(procReadData), .busy(busy), .scannerHold(scannerHold),
      .clearOtherRequests(clearOtherRequests));
   proc_mem_checker i_proc_mem_checker (.clk(clk),
      .rst_n(rst_n), .procMemRequest(link.procMemRequest),
      .procStoreSelect(link.procStoreSelect),
      .procAddressLines(link.procAddressLines), .procReply(link.procReply),
      .scannerAtProc(scannerAtProc), .memoryBusyIn(memoryBusyIn),
      .memoryDataReady(memoryDataReady), .grantRoute(grantRoute), .storeCycle(storeCycle),
      .memoryCycleRequest(memoryCycleRequest), .readPathEnable(readPathEnable), .busy(busy),
      .scannerHold(scannerHold), .clearOtherRequests(clearOtherRequests));
   // memory side
   // data lines carry the inverse outside the ready window so stale values never match
   always @(posedge clk) begin
      memCount <= (memoryCycleRequest === 1'b1) ? 1 : ((memCount != 0) ? memCount + 1 : 0);
      memoryBusyIn <= (memCount != 0) && (memCount < busyHold);
      memoryDataReady <= (memCount >= 3) && (memCount < 6);
      memReadData <= (memCount >= 3 && memCount < 6) ? memWord : ~memWord;
   end
   always @(negedge clk) begin
      if (grantRoute === 1'b1) begin
         sawStore = storeCycle;
         sawRead = readPathEnable;
         sawAddr = memAddress;
         sawWrite = memWriteData;
      end
      if (clearOtherRequests === 1'b1) sawClear = 1'b1;
      if (memoryCycleRequest === 1'b1) lastGap = memCount;
   end
   task automatic check(input logic ok, input string what);
      testsRun++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", testsRun, mismatches);
      if (mismatches == 0 && testsRun > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic access(input logic st, input logic [`PMR_ADDR_W-1:0] a,
      input logic [`PMR_DATA_W-1:0] d);
      int n;
      sawClear = 1'b0;
      @(posedge clk);
      reqValid <= 1'b1;
      reqStore <= st;
      reqAddress <= a;
      reqData <= d;
      memWord <= ~d;
      @(posedge clk);
      reqValid <= 1'b0;
      @(negedge clk);
      check(reqReady === 1'b0, "host did not take the request");
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (done !== 1'b1 && n < 200);
      check(done === 1'b1, "access never finished");
      check(reqReady === 1'b1, "host not ready after reply");
   endtask
   task automatic readScenario();
      access(1'b0, 12'hA5C, 17'h1F0F0);
      check(sawStore === 1'b0 && sawRead === 1'b1, "read path state");
      check(sawAddr === 12'hA5C && sawClear === 1'b1, "address route");
      check(procReadData === 17'h00F0F, "read data");
   endtask
   task automatic storeScenario();
      access(1'b1, 12'hFFF, 17'h1ABCD);
      check(sawStore === 1'b1 && sawRead === 1'b0, "store path state");
      check(sawAddr === 12'hFFF && sawWrite === 17'h1ABCD, "store route");
   endtask
   task automatic scannerScenario();
      scannerAtProc <= 1'b0;
      fork
         access(1'b0, 12'h001, 17'h00001);
         begin
            repeat (12) @(negedge clk);
            check(grantRoute === 1'b0 && scannerHold === 1'b0, "grant without scanner");
            @(posedge clk);
            scannerAtProc <= 1'b1;
         end
      join
   endtask
   task automatic slowBusyScenario();
      busyHold = 40;
      access(1'b0, 12'h800, 17'h10000);
      check(busy === 1'b1, "busy while memory busy");
      access(1'b1, 12'h7FF, 17'h0FFFF);
      check(lastGap > 40, "next cycle before memory idle");
      busyHold = 8;
   endtask
   initial begin
      #100000;
      mismatches++;
      conclude();
   end
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      scannerAtProc <= 1'b1;
      readScenario();
      storeScenario();
      scannerScenario();
      slowBusyScenario();
      conclude();
   end
endmodule
`default_nettype wire
